// *** rtl/homing_sequencer.sv ***
// Four-step homing sequencer with an AHB-Lite register slave
// Function
// - Four steps run in order from config array
// - Step word: speed, filter, polarity, direction, source
// - Direction bit 0 positive, 1 negative
// - Source zero disables the step, no motion
// - Source 1: torque above limit, polarity one
// - Sources 2 to 9 pick inputs one-eight
// - Source 10 runs for filter-set time only
// - Polarity selects low or high active input
// - Filter needs 2^n consecutive true cycles
// - Relative speed scales base speed 0-100%
// - Completion loads position from 32-bit offset
// - Completion stores position minus offset
// - Completion copies done mode to mode register
// - Base speed unit is positions/s over 16
// - Acceleration unit positions/s^2 over 256, always applied
// - Torque limit is unsigned 16-bit mNm
// - Limit input forces shutdown or quick-halt mode
// - Filter and sampling advance at 2 kHz
`timescale 1ns/1ps
`default_nettype none

module homing_sequencer #(
   parameter int unsigned REG_TICK_CYCLES = homing_pkg::REG_TICK_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic [31:0] motor_position_value_in,
   input  wire logic [15:0] motor_torque_in,
   input  wire logic [7:0]  digital_input_in,
   output logic             motor_run_out,
   output logic             motor_direction_out,
   output logic      [15:0] motor_speed_out,
   output logic      [15:0] motor_acceleration_out,
   output logic             position_load_out,
   output logic      [31:0] position_load_value_out,
   output logic      [15:0] operating_mode_out,
   output logic             homing_busy_out
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [3:0][15:0]       cfg;
      logic [15:0]            legacy_ofs;
      logic [15:0]            base_speed;
      logic [15:0]            accel;
      logic [15:0]            torque_lim;
      logic [15:0]            done_mode;
      logic [15:0]            correction;
      logic [31:0]            offset;
      logic [15:0]            op_mode;
      logic [5:0]             limit_cfg;
      homing_pkg::seq_state_t st;
      logic [1:0]             step;
      logic [15:0]            filt_cnt;
      logic [15:0]            tick_cnt;
      logic                   tick;
      logic                   done;
      logic                   run;
      logic                   dir;
      logic [15:0]            speed;
      logic                   load;
      logic [31:0]            load_val;
      logic                   wr_pend;
      logic [9:0]             wr_idx;
      logic [31:0]            rdata;
      logic                   busy;
   } state_t;

   state_t q;
   state_t d;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Step speed as a fraction rel/15 of the base speed
   function automatic logic [15:0] scale_speed(input logic [15:0] base,
                                               input logic [3:0]  rel);
      logic [19:0] prod;
      prod = base * rel;
      return 16'(prod / 20'(homing_pkg::REL_FULL));
   endfunction

   // Consecutive true cycles needed for a filter setting
   function automatic logic [15:0] filter_target(input logic [3:0] setting);
      return 16'h0001 << setting;
   endfunction

   // Register read mux over a given state copy
   function automatic logic [31:0] reg_read(input state_t s,
                                            input logic [9:0] idx);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (idx >= homing_pkg::IDX_STEP0 && idx <= homing_pkg::IDX_STEP3) begin
         r = {16'h0000, s.cfg[2'(idx - homing_pkg::IDX_STEP0)]};
      end else begin
         unique case (idx)
            homing_pkg::IDX_LEGACY_OFS: r = {16'h0000, s.legacy_ofs};
            homing_pkg::IDX_SPEED:      r = {16'h0000, s.base_speed};
            homing_pkg::IDX_ACCEL:      r = {16'h0000, s.accel};
            homing_pkg::IDX_TORQUE:     r = {16'h0000, s.torque_lim};
            homing_pkg::IDX_DONE_MODE:  r = {16'h0000, s.done_mode};
            homing_pkg::IDX_CORRECTION: r = {16'h0000, s.correction};
            homing_pkg::IDX_OFFSET:     r = s.offset;
            homing_pkg::IDX_OP_MODE:    r = {16'h0000, s.op_mode};
            homing_pkg::IDX_LIMIT:      r = {26'h0, s.limit_cfg};
            homing_pkg::IDX_CONTROL: begin
               r[homing_pkg::CTL_BUSY] = (s.st != homing_pkg::ST_IDLE);
               r[homing_pkg::CTL_DONE] = s.done;
               r[homing_pkg::CTL_STEP +: 2] = s.step;
            end
            default: r = 32'h0000_0000;
         endcase
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Combinational next state
   logic [15:0] cur_cfg;
   logic [3:0]  src;
   logic        pol;
   logic        cond_raw;
   logic        cond_met;
   logic [15:0] filt_next;
   logic        limit_hit;
   logic [3:0]  lim_sel;
   logic        start_req;
   logic [31:0] pos_diff;

   always_comb begin
      d = q;
      d.load = 1'b0;
      start_req = 1'b0;

      // Data phase of a write that was taken in the previous cycle
      if (q.wr_pend) begin
         if (q.wr_idx >= homing_pkg::IDX_STEP0 &&
             q.wr_idx <= homing_pkg::IDX_STEP3) begin
            d.cfg[2'(q.wr_idx - homing_pkg::IDX_STEP0)] = hwdata_in[15:0];
         end else begin
            unique case (q.wr_idx)
               homing_pkg::IDX_LEGACY_OFS: d.legacy_ofs = hwdata_in[15:0];
               homing_pkg::IDX_SPEED:      d.base_speed = hwdata_in[15:0];
               homing_pkg::IDX_ACCEL:      d.accel      = hwdata_in[15:0];
               homing_pkg::IDX_TORQUE:     d.torque_lim = hwdata_in[15:0];
               homing_pkg::IDX_DONE_MODE:  d.done_mode  = hwdata_in[15:0];
               homing_pkg::IDX_OFFSET:     d.offset     = hwdata_in;
               homing_pkg::IDX_OP_MODE:    d.op_mode    = hwdata_in[15:0];
               homing_pkg::IDX_LIMIT:      d.limit_cfg  = hwdata_in[5:0];
               homing_pkg::IDX_CONTROL:
                  start_req = hwdata_in[homing_pkg::CTL_START];
               default: ;
            endcase
         end
      end

      // Regulator cycle strobe at 2 kHz
      d.tick = 1'b0;
      if (q.tick_cnt == 16'(REG_TICK_CYCLES - 1)) begin
         d.tick_cnt = 16'h0000;
         d.tick = 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 16'h0001;
      end

      // Current step fields
      cur_cfg = q.cfg[q.step];
      src = cur_cfg[homing_pkg::SRC_MSB:homing_pkg::SRC_LSB];
      pol = cur_cfg[homing_pkg::POL_BIT];

      // Condition input selection and polarity
      if (src == homing_pkg::SRC_TORQUE) begin
         cond_raw = (motor_torque_in > q.torque_lim) && pol;
      end else if (src == homing_pkg::SRC_TIMED) begin
         cond_raw = 1'b1;
      end else begin
         cond_raw = ~(digital_input_in[3'(src - homing_pkg::SRC_IN1)] ^ pol);
      end

      // Consecutive-cycle filter
      filt_next = q.filt_cnt + 16'h0001;
      cond_met = cond_raw &&
                 (filt_next == filter_target(cur_cfg[homing_pkg::FLT_MSB:homing_pkg::FLT_LSB]));
      pos_diff = motor_position_value_in - q.offset;

      // Sequencer
      unique case (q.st)
         homing_pkg::ST_IDLE: begin
            if (start_req) begin
               d.st = homing_pkg::ST_LOAD;
               d.step = 2'h0;
               d.done = 1'b0;
            end
         end
         homing_pkg::ST_LOAD: begin
            d.filt_cnt = 16'h0000;
            if (src == homing_pkg::SRC_NONE || src > homing_pkg::SRC_TIMED) begin
               // Disabled step: no motion, move on at once
               d.run = 1'b0;
               if (q.step == homing_pkg::LAST_STEP) begin
                  d.st = homing_pkg::ST_DONE;
               end else begin
                  d.step = q.step + 2'h1;
               end
            end else begin
               d.st = homing_pkg::ST_RUN;
               d.run = 1'b1;
               d.dir = cur_cfg[homing_pkg::DIR_BIT];
            end
         end
         homing_pkg::ST_RUN: begin
            if (q.tick) begin
               if (cond_met) begin
                  d.run = 1'b0;
                  d.filt_cnt = 16'h0000;
                  if (q.step == homing_pkg::LAST_STEP) begin
                     d.st = homing_pkg::ST_DONE;
                  end else begin
                     d.st = homing_pkg::ST_LOAD;
                     d.step = q.step + 2'h1;
                  end
               end else if (cond_raw) begin
                  d.filt_cnt = filt_next;
               end else begin
                  d.filt_cnt = 16'h0000;
               end
            end
         end
         homing_pkg::ST_DONE: begin
            // Completion actions
            d.load = 1'b1;
            d.load_val = q.offset;
            d.correction = pos_diff[15:0];
            d.op_mode = q.done_mode;
            d.done = 1'b1;
            d.st = homing_pkg::ST_IDLE;
         end
      endcase

      // Limit switch forces a halt mode and aborts homing
      lim_sel = q.limit_cfg[homing_pkg::LIM_SEL_MSB:0];
      limit_hit = 1'b0;
      if (lim_sel != 4'h0 && lim_sel <= 4'h8) begin
         limit_hit = ~(digital_input_in[3'(lim_sel - 4'h1)] ^
                       q.limit_cfg[homing_pkg::LIM_POL]);
      end
      if (limit_hit) begin
         d.op_mode = q.limit_cfg[homing_pkg::LIM_QUICK] ?
                     homing_pkg::MODE_QUICKSTOP : homing_pkg::MODE_SHUTDOWN;
         d.st = homing_pkg::ST_IDLE;
         d.run = 1'b0;
         d.load = 1'b0;
         d.done = q.done;
      end

      // Step speed registered while driven, zero otherwise; acceleration passed through
      if (d.run) begin
         d.speed = scale_speed(q.base_speed,
                               cur_cfg[homing_pkg::SPD_MSB:homing_pkg::SPD_LSB]);
      end else begin
         d.speed = 16'h0000;
      end
      // Busy flag kept in a flop so the output comes straight from a register
      d.busy = (d.st != homing_pkg::ST_IDLE);

      // Address phase capture; read data reflects this cycle's write
      d.wr_pend = 1'b0;
      if (hsel_in && htrans_in[1] && hready_in) begin
         d.wr_pend = hwrite_in;
         d.wr_idx = haddr_in[homing_pkg::ADDR_LSB +: 10];
         if (!hwrite_in) begin
            d.rdata = reg_read(d, haddr_in[homing_pkg::ADDR_LSB +: 10]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs from flip-flops, except hresp tied to zero
   logic hready_q;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         hready_q <= 1'b0;
      end else begin
         hready_q <= 1'b1;
      end
   end

   assign hrdata_out = q.rdata;
   assign hreadyout_out = hready_q;
   assign hresp_out = 1'b0;
   assign motor_run_out = q.run;
   assign motor_direction_out = q.dir;
   assign motor_speed_out = q.speed;
   assign motor_acceleration_out = q.accel;
   assign position_load_out = q.load;
   assign position_load_value_out = q.load_val;
   assign operating_mode_out = q.op_mode;
   assign homing_busy_out = q.busy;

endmodule

`default_nettype wire

// *** shared/homing_pkg.sv ***
// Package for the four-step homing sequencer: register map, fields, timing
package homing_pkg;
   // Register indices; the byte address is four times the index
   localparam logic [9:0] IDX_STEP0      = 10'h1e0;
   localparam logic [9:0] IDX_STEP3      = 10'h1e3;
   localparam logic [9:0] IDX_LEGACY_OFS = 10'h1ea;
   localparam logic [9:0] IDX_SPEED      = 10'h1eb;
   localparam logic [9:0] IDX_ACCEL      = 10'h1ec;
   localparam logic [9:0] IDX_TORQUE     = 10'h1ed;
   localparam logic [9:0] IDX_DONE_MODE  = 10'h1ee;
   localparam logic [9:0] IDX_CORRECTION = 10'h1ef;
   localparam logic [9:0] IDX_OFFSET     = 10'h1f0;
   localparam logic [9:0] IDX_CONTROL    = 10'h1f1;
   localparam logic [9:0] IDX_LIMIT      = 10'h1f2;
   localparam logic [9:0] IDX_OP_MODE    = 10'h190;
   localparam int         ADDR_LSB       = 2;
   // Step configuration fields
   localparam int SPD_MSB = 15;
   localparam int SPD_LSB = 12;
   localparam int FLT_MSB = 11;
   localparam int FLT_LSB = 8;
   localparam int POL_BIT = 5;
   localparam int DIR_BIT = 4;
   localparam int SRC_MSB = 3;
   localparam int SRC_LSB = 0;
   // Condition sources
   localparam logic [3:0] SRC_NONE   = 4'h0;
   localparam logic [3:0] SRC_TORQUE = 4'h1;
   localparam logic [3:0] SRC_IN1    = 4'h2;
   localparam logic [3:0] SRC_IN8    = 4'h9;
   localparam logic [3:0] SRC_TIMED  = 4'ha;
   localparam logic [3:0] REL_FULL   = 4'hf;
   // Control and limit register fields
   localparam int CTL_START = 0;
   localparam int CTL_BUSY  = 0;
   localparam int CTL_DONE  = 1;
   localparam int CTL_STEP  = 2;
   localparam int LIM_SEL_MSB = 3;
   localparam int LIM_POL     = 4;
   localparam int LIM_QUICK   = 5;
   // Mode values forced by a limit switch; values are arbitrary
   localparam logic [15:0] MODE_SHUTDOWN  = 16'h0001;
   localparam logic [15:0] MODE_QUICKSTOP = 16'h0002;
   localparam logic [1:0]  LAST_STEP      = 2'h3;
   // Regulator cycle timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned REG_HZ = 2_000;
   localparam int unsigned REG_TICK_CYCLES = CLK_HZ / REG_HZ;
   // Sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_DONE} seq_state_t;
endpackage

// *** tb/four_step_homing_sequencer_tb.sv ***
// Self-checking bench for the four-step homing sequencer
`timescale 1ns/1ps
`default_nettype none
module four_step_homing_sequencer_tb;
   logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, pos, last_pos, ld_val, seed = 32'h5416;
   logic [15:0] trq, trq_cmd = 16'h0, spd, acc, mode;
   logic [7:0]  din, din_cmd = 8'h00;
   logic        hrdy, hresp, run, dir, ld, busy, pol, dr;
   logic [3:0]  rel, f;
   logic [31:0] v [8];
   logic [31:0] exp_q [$];
   logic [9:0]  ix [8] = '{homing_pkg::IDX_STEP0, homing_pkg::IDX_STEP3, homing_pkg::IDX_LEGACY_OFS,
      homing_pkg::IDX_SPEED, homing_pkg::IDX_ACCEL, homing_pkg::IDX_TORQUE,
      homing_pkg::IDX_OFFSET, homing_pkg::IDX_DONE_MODE};
   int          n_fail = 0, compares = 0, cyc = 0, n;
   always #10 clk = ~clk;
   homing_sequencer #(.REG_TICK_CYCLES(4)) i_dut (.clk_in(clk), .rst_in(rst), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
      .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
      .hresp_out(hresp), .motor_position_value_in(pos), .motor_torque_in(trq),
      .digital_input_in(din), .motor_run_out(run), .motor_direction_out(dir),
      .motor_speed_out(spd), .motor_acceleration_out(acc), .position_load_out(ld),
      .position_load_value_out(ld_val), .operating_mode_out(mode), .homing_busy_out(busy));
   homing_motor_model i_motor (.clk_in(clk), .rst_in(rst), .run_in(run), .dir_in(dir),
      .load_in(ld), .load_value_in(ld_val), .torque_cmd_in(trq_cmd), .din_cmd_in(din_cmd),
      .position_out(pos), .last_position_out(last_pos), .torque_out(trq), .din_out(din));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic take(input string nm, input logic [31:0] seen);
      if (exp_q.size() == 0) begin
         n_fail++;
         $display("[ERR] %s expected none seen %h", nm, seen);
      end else check(nm, seen, exp_q.pop_front());
   endtask
   // Single AHB-Lite word transfer, held until hready is sampled high
   task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2; haddr <= {20'h0, idx, 2'b00};
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
   endtask
   task automatic finish_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Monitor: read data and position loads against the oldest note
   always @(negedge clk) begin
      if (rd_dp) take("read", hrdata);
      if (ld === 1'b1) take("load", ld_val);
      rd_dp = hsel & htrans[1] & !hwrite;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         finish_test;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Register write and read back, unmapped and read-only places
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         v[i] = (i == 6) ? seed : {16'h0, seed[15:0]};
         bus(1'b1, ix[i], v[i]);
      end
      for (int i = 0; i < 8; i++) begin
         exp_q.push_back(v[i]);
         bus(1'b0, ix[i], 32'h0);
      end
      check("accel", {16'h0, acc}, v[4]);
      bus(1'b1, homing_pkg::IDX_CORRECTION, 32'hffff);
      exp_q.push_back(32'h0);
      bus(1'b0, homing_pkg::IDX_CORRECTION, 32'h0);
      exp_q.push_back(32'h0);
      bus(1'b0, 10'h1f8, 32'h0);
      for (int s = 0; s < 4; s++) bus(1'b1, homing_pkg::IDX_STEP0 + 10'(s), 32'h0);
      bus(1'b1, homing_pkg::IDX_TORQUE, 32'h0100);
      $display("test registers done");
      // One homing run per condition source, remaining steps disabled
      for (int s = 1; s <= 10; s++) begin
         seed = lfsr(seed);
         f = 4'(s % 3);
         pol = (s == 1) | seed[0];
         dr = seed[1];
         rel = seed[7:4];
         din_cmd <= pol ? 8'h00 : 8'hff;
         trq_cmd <= 16'h0000;
         bus(1'b1, homing_pkg::IDX_STEP0, {16'h0, rel, f, 2'b00, pol, dr, 4'(s)});
         exp_q.push_back(v[6]);
         bus(1'b1, homing_pkg::IDX_CONTROL, 32'h1);
         n = 0;
         while (run !== 1'b1 && n < 100) begin @(negedge clk); n++; end
         @(negedge clk);
         @(negedge clk);
         check("direction", {31'h0, dir}, {31'h0, dr});
         check("speed", {16'h0, spd}, 32'(v[3][15:0] * rel / 15));
         @(posedge clk);
         if (s == 1) trq_cmd <= 16'h0101;
         else if (s < 10) din_cmd[s - 2] <= pol;
         n = 0;
         while (run === 1'b1 && n < 400) begin @(negedge clk); n++; end
         check("filter", {31'h0, n >= (4 << f) - 7 && n <= (4 << f) + 8}, 32'h1);
         n = 0;
         while (busy !== 1'b0 && n < 100) begin @(negedge clk); n++; end
         exp_q.push_back(32'h0000_000e);
         bus(1'b0, homing_pkg::IDX_CONTROL, 32'h0);
         exp_q.push_back({16'h0, last_pos[15:0] - v[6][15:0]});
         bus(1'b0, homing_pkg::IDX_CORRECTION, 32'h0);
         exp_q.push_back(v[7]);
         bus(1'b0, homing_pkg::IDX_OP_MODE, 32'h0);
      end
      $display("test homing done");
      // Limit switch on input one, active high, quick halt
      din_cmd <= 8'h00;
      bus(1'b1, homing_pkg::IDX_LIMIT, 32'h31);
      din_cmd <= 8'h01;
      repeat (4) @(negedge clk);
      check("limit mode", {16'h0, mode}, {16'h0, homing_pkg::MODE_QUICKSTOP});
      $display("test limit done");
      finish_test;
   end
endmodule
`default_nettype wire

// *** tb/homing_motor_model.sv ***
// Motor model: position counter, torque sense and digital inputs
`timescale 1ns/1ps
`default_nettype none
module homing_motor_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        run_in,
   input  wire logic        dir_in,
   input  wire logic        load_in,
   input  wire logic [31:0] load_value_in,
   input  wire logic [15:0] torque_cmd_in,
   input  wire logic [7:0]  din_cmd_in,
   output logic      [31:0] position_out,
   output logic      [31:0] last_position_out,
   output logic      [15:0] torque_out,
   output logic      [7:0]  din_out
);
   // Sensors follow the commands; position moves one count a cycle while driven
   always_ff @(posedge clk_in) begin
      torque_out <= torque_cmd_in;
      din_out    <= din_cmd_in;
      if (rst_in) begin
         position_out <= 32'h0000_1000;
      end else if (load_in) begin
         last_position_out <= position_out;
         position_out      <= load_value_in;
      end else if (run_in) begin
         position_out <= dir_in ? position_out - 32'h1 : position_out + 32'h1;
      end
   end
endmodule
`default_nettype wire

// *** tb/homing_sequencer_props.sv ***
// Checker for the homing sequencer top ports, bound at the foot
`timescale 1ns/1ps
`default_nettype none
module homing_sequencer_props (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0]  htrans_in,
   input wire logic        hwrite_in,
   input wire logic [31:0] hwdata_in,
   input wire logic        hready_in,
   input wire logic        hreadyout_out,
   input wire logic        hresp_out,
   input wire logic        motor_run_out,
   input wire logic [15:0] motor_speed_out,
   input wire logic        position_load_out,
   input wire logic [31:0] position_load_value_out,
   input wire logic [15:0] operating_mode_out,
   input wire logic        homing_busy_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic        wr_q;
   logic [9:0]  ix_q;
   logic [31:0] ofs_q;
   logic [15:0] md_q;
   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of the offset and completion mode written over the bus
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_q  <= 1'b0;
         ix_q  <= 10'h000;
         ofs_q <= 32'h0000_0000;
         md_q  <= 16'h0000;
      end else begin
         wr_q <= hsel_in & htrans_in[1] & hready_in & hwrite_in;
         ix_q <= haddr_in[11:2];
         if (wr_q && ix_q == homing_pkg::IDX_OFFSET) ofs_q <= hwdata_in;
         if (wr_q && ix_q == homing_pkg::IDX_DONE_MODE) md_q <= hwdata_in[15:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_resp_okay: assert property (hresp_out == 1'b0) else $error("bus response not okay");
   a_ready_up: assert property (!$past(rst_in) |-> hreadyout_out)
      else $error("slave not ready after reset");
   a_run_busy: assert property (motor_run_out |-> homing_busy_out)
      else $error("motor driven while idle");
   a_speed_idle: assert property (!motor_run_out [*2] |-> motor_speed_out == 16'h0000)
      else $error("speed while not running");
   a_load_pulse: assert property (position_load_out |=> !position_load_out)
      else $error("load longer than one cycle");
   a_load_value: assert property (position_load_out |-> position_load_value_out == ofs_q)
      else $error("load value differs from offset");
   a_mode_copy: assert property (position_load_out |-> ##[0:2] operating_mode_out == md_q)
      else $error("mode not copied at completion");
   a_busy_ends: assert property (position_load_out |-> ##[0:2] !homing_busy_out)
      else $error("busy stays after completion");
endmodule
bind homing_sequencer homing_sequencer_props i_props (.clk_in, .rst_in, .hsel_in, .haddr_in,
   .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .motor_run_out,
   .motor_speed_out, .position_load_out, .position_load_value_out, .operating_mode_out,
   .homing_busy_out);
`default_nettype wire
